// File: rtc_alarm_interrupt_outputs_tb.sv
// self-checking bench: axi4-lite master, alarm scenarios, line checks through the host model
// assumes a fast second (8 clocks) so alarms fire within a few dozen cycles
`timescale 1ns/100ps
`include "rtcai_regs.svh"
module rtc_alarm_interrupt_outputs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, oe_a, oe_b, lvl_a, lvl_b, line_a, line_b;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int n_compared = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // a second of 8 clocks stands in for the oscillator timebase so alarms come quickly
  rtcai_top #(.TICK_CYCLES(8)) u_dut (
    .CLK_SYS_IN(clk), .RESETN_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .IRQ_OUT(irq),
    .ALARM_IRQ_OUT_A_OUT(lvl_a), .ALARM_IRQ_OUT_A_OE_OUT(oe_a),
    .ALARM_IRQ_OUT_B_OUT(lvl_b), .ALARM_IRQ_OUT_B_OE_OUT(oe_b)
  );

  rtcai_host_model u_host (
    .oe_a_in(oe_a), .oe_b_in(oe_b), .lvl_a_in(lvl_a), .lvl_b_in(lvl_b),
    .line_a_out(line_a), .line_b_out(line_b)
  );

  task automatic stop_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one settled sample per cycle; a wait that runs out ends the run
  task automatic step(inout int n);
    @(negedge clk);
    n++;
    if (n > 300) begin
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      stop_test();
    end
  endtask

  // address and data offered together, each released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      step(n);
      @(posedge clk);
      if (!ad && awready) awvalid <= 1'b0;
      if (!wd && wready) wvalid <= 1'b0;
      ad = ad | awready;
      wd = wd | wready;
    end
    do step(n); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do step(n); while (!rvalid);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // line levels as the host sees them, plus the level interrupt
  task automatic lines(input logic ea, input logic eb, input logic ei);
    int n;
    n = 0;
    while ({line_a, line_b, irq} !== {ea, eb, ei}) step(n);
    chk({29'h0, line_a, line_b, irq}, {29'h0, ea, eb, ei});
  endtask

  task automatic t_reset_values();
    lines(1'b1, 1'b1, 1'b0);
    rd(`RTCAI_CTRL_OFF, 32'h0, `RTCAI_RESP_OKAY);
    rd(`RTCAI_STATUS_OFF, 32'h0, `RTCAI_RESP_OKAY);
    rd(`RTCAI_MASK_OFF, 32'h0, `RTCAI_RESP_OKAY);
  endtask

  // unmapped place: no effect, error answer on both channels
  task automatic t_unmapped();
    wr(8'h18, 32'hffffffff, `RTCAI_RESP_SLVERR);
    rd(8'h18, 32'h0, `RTCAI_RESP_SLVERR);
  endtask

  // a partial write changes only the lanes whose strobe is set
  task automatic t_strobes();
    wr(`RTCAI_ALARM1_OFF, 32'h11223344, `RTCAI_RESP_OKAY);
    @(posedge clk);
    wstrb <= 4'h2;
    wr(`RTCAI_ALARM1_OFF, 32'hffffffff, `RTCAI_RESP_OKAY);
    @(posedge clk);
    wstrb <= 4'hf;
    rd(`RTCAI_ALARM1_OFF, 32'h1122ff44, `RTCAI_RESP_OKAY);
  endtask

  // every field carries over at once into an alarm that ignores no field
  task automatic t_rollover();
    wr(`RTCAI_ALARM0_OFF, 32'h01000000, `RTCAI_RESP_OKAY);
    wr(`RTCAI_TIME_OFF, 32'h07173b3b, `RTCAI_RESP_OKAY);
    rd(`RTCAI_TIME_OFF, 32'h07173b3b, `RTCAI_RESP_OKAY);
    wr(`RTCAI_CTRL_OFF, 32'h1, `RTCAI_RESP_OKAY);
    lines(1'b0, 1'b1, 1'b0);
    rd(`RTCAI_STATUS_OFF, 32'h1, `RTCAI_RESP_OKAY);
    wr(`RTCAI_CTRL_OFF, 32'h0, `RTCAI_RESP_OKAY);
    wr(`RTCAI_STATUS_OFF, 32'h1, `RTCAI_RESP_OKAY);
    lines(1'b1, 1'b1, 1'b0);
  endtask

  // alarm 0 at second 2, alarm 1 at second 4, other fields ignored
  task automatic t_alarms_and_routing();
    wr(`RTCAI_ALARM0_OFF, 32'h80808002, `RTCAI_RESP_OKAY);
    wr(`RTCAI_ALARM1_OFF, 32'h80808004, `RTCAI_RESP_OKAY);
    wr(`RTCAI_CTRL_OFF, 32'h1, `RTCAI_RESP_OKAY);
    wr(`RTCAI_TIME_OFF, 32'h01000000, `RTCAI_RESP_OKAY);
    lines(1'b0, 1'b1, 1'b0);
    wr(`RTCAI_CTRL_OFF, 32'h3, `RTCAI_RESP_OKAY);
    lines(1'b0, 1'b0, 1'b0);
    rd(`RTCAI_STATUS_OFF, 32'h3, `RTCAI_RESP_OKAY);
    wr(`RTCAI_MASK_OFF, 32'h2, `RTCAI_RESP_OKAY);
    lines(1'b0, 1'b0, 1'b1);
    wr(`RTCAI_MASK_OFF, 32'h0, `RTCAI_RESP_OKAY);
    lines(1'b0, 1'b0, 1'b0);
    wr(`RTCAI_STATUS_OFF, 32'h1, `RTCAI_RESP_OKAY);
    lines(1'b1, 1'b0, 1'b0);
    wr(`RTCAI_CTRL_OFF, 32'h7, `RTCAI_RESP_OKAY);
    lines(1'b0, 1'b0, 1'b0);
    rd(`RTCAI_CTRL_OFF, 32'h7, `RTCAI_RESP_OKAY);
    wr(`RTCAI_STATUS_OFF, 32'h2, `RTCAI_RESP_OKAY);
    lines(1'b1, 1'b1, 1'b0);
    rd(`RTCAI_STATUS_OFF, 32'h0, `RTCAI_RESP_OKAY);
  endtask

  // second reset in mid-run, with line a held low, clears state and releases both lines
  task automatic t_mid_reset();
    wr(`RTCAI_ALARM0_OFF, 32'h80808080, `RTCAI_RESP_OKAY);
    wr(`RTCAI_CTRL_OFF, 32'h1, `RTCAI_RESP_OKAY);
    lines(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    lines(1'b1, 1'b1, 1'b0);
    rd(`RTCAI_CTRL_OFF, 32'h0, `RTCAI_RESP_OKAY);
    rd(`RTCAI_STATUS_OFF, 32'h0, `RTCAI_RESP_OKAY);
    rd(`RTCAI_ALARM0_OFF, 32'h0, `RTCAI_RESP_OKAY);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_unmapped();
    t_strobes();
    t_rollover();
    t_alarms_and_routing();
    t_mid_reset();
    stop_test();
  end
endmodule

// File: rtcai_alarm_match.sv
// compares the running time word against one alarm word, field by field
// assumes both words use the one-byte-per-field layout; bit 7 of an alarm byte ignores that field
`timescale 1ns/100ps
module rtcai_alarm_match (
  input wire logic [31:0] time_in,  // current time word
  input wire logic [31:0] alarm_in, // alarm word with ignore bits
  output logic match_out            // all fields hit
);
  logic [3:0] hit;

  // one compare per field; an ignored field always hits
  for (genvar i = 0; i < 4; i++) begin : g_field
    assign hit[i] = alarm_in[8*i+7] | (alarm_in[8*i+6 -: 7] == time_in[8*i+6 -: 7]);
  end

  assign match_out = &hit;
endmodule

// File: rtcai_host_model.sv
// host side of the two alarm lines: pull-ups and the resolved line levels
// assumes the block pulls a line low only while its enable is high
`timescale 1ns/100ps
module rtcai_host_model (
  input wire logic oe_a_in,   // pin a pull-down enable
  input wire logic oe_b_in,   // pin b pull-down enable
  input wire logic lvl_a_in,  // pin a driven level
  input wire logic lvl_b_in,  // pin b driven level
  output logic line_a_out,    // line a as the host sees it
  output logic line_b_out     // line b as the host sees it
);
  // a released line floats up to the pull-up, never keeps the last driven level
  assign line_a_out = oe_a_in ? lvl_a_in : 1'b1;
  assign line_b_out = oe_b_in ? lvl_b_in : 1'b1;
endmodule

// File: rtcai_pkg.sv
// types of the alarm interrupt block: the single packed state of the top module
// assumes rtcai_regs.svh supplies all numbers
package rtcai_pkg;

  // whole state of the top module, registered as one word
  typedef struct packed {
    logic [31:0] div;
    logic tick;
    logic en0;
    logic en1;
    logic route;
    logic [1:0] status;
    logic [1:0] mask;
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] day;
    logic [31:0] alm0;
    logic [31:0] alm1;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic irq;
    logic oe_a;
    logic oe_b;
  } rtcai_state_t;

endpackage

// File: rtcai_regs.svh
// register offsets, field positions, reset values and timing counts of the alarm interrupt block
// assumes a 200 MHz system clock and a 32-bit axi4-lite register port
`ifndef RTCAI_REGS_SVH
`define RTCAI_REGS_SVH

// byte offsets of the registers
`define RTCAI_CTRL_OFF 8'h00
`define RTCAI_STATUS_OFF 8'h04
`define RTCAI_MASK_OFF 8'h08
`define RTCAI_TIME_OFF 8'h0c
`define RTCAI_ALARM0_OFF 8'h10
`define RTCAI_ALARM1_OFF 8'h14

// control register fields
`define RTCAI_CTRL_EN0 0
`define RTCAI_CTRL_EN1 1
`define RTCAI_CTRL_ROUTE 2

// time and alarm word fields (one byte per field, bit 7 of each byte ignores it in alarms)
`define RTCAI_SEC_LSB 0
`define RTCAI_MIN_LSB 8
`define RTCAI_HOUR_LSB 16
`define RTCAI_DAY_LSB 24
`define RTCAI_SEC_MAX 6'h3b
`define RTCAI_MIN_MAX 6'h3b
`define RTCAI_HOUR_MAX 5'h17
`define RTCAI_DAY_MAX 3'h7
`define RTCAI_DAY_RST 3'h1

// bus answers
`define RTCAI_RESP_OKAY 2'h0
`define RTCAI_RESP_SLVERR 2'h2

// timing: one second of timekeeping at the system clock rate
`define RTCAI_CLK_PERIOD_NS 5
`define RTCAI_SECOND_NS 1000000000
`define RTCAI_TICK_CYCLES (`RTCAI_SECOND_NS / `RTCAI_CLK_PERIOD_NS)

`endif

// File: rtcai_top.sv
// alarm interrupt block: timekeeping, two alarms, two open-drain alarm pins, axi4-lite registers
// assumes one 200 MHz clock, an async active-low reset and pull-ups on both alarm pins
//
// Contract
// - pin a follows alarm 0 alone, or either alarm when routing bit set.
// - pin b is driven from alarm 1 only, never from alarm 0.
// - each pin stays low while its flag and enable are set, else released.
// - both pins are active low open drain; outside pull-up makes released level high.
// - timekeeping and both pins keep running whenever the block has power; a reset here clears the time and releases both pins.
// - each alarm matches seconds, minutes, hours, day; any field may be ignored.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "rtcai_regs.svh"
module rtcai_top #(
  parameter int TICK_CYCLES = `RTCAI_TICK_CYCLES // system clocks per second of time
) (
  input wire logic CLK_SYS_IN,              // system clock, 200 MHz
  input wire logic RESETN_IN,               // async reset, active low
  input wire logic [7:0] S_AXI_AWADDR_IN,   // write address
  input wire logic S_AXI_AWVALID_IN,        // write address valid
  output logic S_AXI_AWREADY_OUT,           // write address ready
  input wire logic [31:0] S_AXI_WDATA_IN,   // write data
  input wire logic [3:0] S_AXI_WSTRB_IN,    // write byte strobes
  input wire logic S_AXI_WVALID_IN,         // write data valid
  output logic S_AXI_WREADY_OUT,            // write data ready
  output logic [1:0] S_AXI_BRESP_OUT,       // write response
  output logic S_AXI_BVALID_OUT,            // write response valid
  input wire logic S_AXI_BREADY_IN,         // write response ready
  input wire logic [7:0] S_AXI_ARADDR_IN,   // read address
  input wire logic S_AXI_ARVALID_IN,        // read address valid
  output logic S_AXI_ARREADY_OUT,           // read address ready
  output logic [31:0] S_AXI_RDATA_OUT,      // read data
  output logic [1:0] S_AXI_RRESP_OUT,       // read response
  output logic S_AXI_RVALID_OUT,            // read data valid
  input wire logic S_AXI_RREADY_IN,         // read data ready
  output logic IRQ_OUT,                     // level interrupt, high while unmasked flag set
  output logic ALARM_IRQ_OUT_A_OUT,         // pin a output level, always low
  output logic ALARM_IRQ_OUT_A_OE_OUT,      // pin a pull-down enable
  output logic ALARM_IRQ_OUT_B_OUT,         // pin b output level, always low
  output logic ALARM_IRQ_OUT_B_OE_OUT       // pin b pull-down enable
);
  rtcai_pkg::rtcai_state_t s;
  rtcai_pkg::rtcai_state_t next_s;
  logic [31:0] time_word;
  logic [1:0] match;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("rtcai_top: TICK_CYCLES must be at least 2");
  end

  // time as one word in the alarm layout
  assign time_word = {5'h00, s.day, 3'h0, s.hour, 2'h0, s.min, 2'h0, s.sec};

  rtcai_alarm_match u_match0 (
    .time_in(time_word),
    .alarm_in(s.alm0),
    .match_out(match[0])
  );

  rtcai_alarm_match u_match1 (
    .time_in(time_word),
    .alarm_in(s.alm1),
    .match_out(match[1])
  );

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // next state: divider, timekeeping, alarm flags, bus slave, pin drive
  always_comb begin
    logic [31:0] wv;
    logic [1:0] clr;
    logic [1:0] ev;
    wv = 32'h0000_0000;
    clr = 2'h0;
    ev = 2'h0;
    next_s = s;
    next_s.tick = 1'b0;
    // free-running second divider; the silicon this mirrors runs it from the crystal clock
    if (s.div == 32'(TICK_CYCLES - 1)) begin
      next_s.div = 32'h0000_0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 32'h0000_0001;
    end
    // timekeeping needs no enable and stops only while RESETN_IN is low, so alarms keep firing outside reset
    if (next_s.tick) begin
      if (s.sec == `RTCAI_SEC_MAX) begin
        next_s.sec = 6'h00;
        if (s.min == `RTCAI_MIN_MAX) begin
          next_s.min = 6'h00;
          if (s.hour == `RTCAI_HOUR_MAX) begin
            next_s.hour = 5'h00;
            next_s.day = (s.day >= `RTCAI_DAY_MAX) ? `RTCAI_DAY_RST : s.day + 3'h1;
          end else begin
            next_s.hour = s.hour + 5'h01;
          end
        end else begin
          next_s.min = s.min + 6'h01;
        end
      end else begin
        next_s.sec = s.sec + 6'h01;
      end
    end
    // a match is judged once, the cycle after the time has moved
    if (s.tick) begin
      ev = match;
    end
    // write address and data taken in either order
    if (s.awready && S_AXI_AWVALID_IN) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = S_AXI_AWADDR_IN;
    end
    if (s.wready && S_AXI_WVALID_IN) begin
      next_s.w_got = 1'b1;
      next_s.wdata = S_AXI_WDATA_IN;
      next_s.wstrb = S_AXI_WSTRB_IN;
    end
    if (s.bvalid && S_AXI_BREADY_IN) begin
      next_s.bvalid = 1'b0;
    end
    // write performed once both halves are held
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RTCAI_RESP_OKAY;
      case (s.awaddr)
        `RTCAI_CTRL_OFF: begin
          wv = merge({29'h0, s.route, s.en1, s.en0}, s.wdata, s.wstrb);
          next_s.en0 = wv[`RTCAI_CTRL_EN0];
          next_s.en1 = wv[`RTCAI_CTRL_EN1];
          next_s.route = wv[`RTCAI_CTRL_ROUTE];
        end
        `RTCAI_STATUS_OFF: begin
          clr = s.wstrb[0] ? s.wdata[1:0] : 2'h0;
        end
        `RTCAI_MASK_OFF: begin
          if (s.wstrb[0]) begin
            next_s.mask = s.wdata[1:0];
          end
        end
        `RTCAI_TIME_OFF: begin
          // writing the time restarts the second so the first tick is a full second away
          wv = merge(time_word, s.wdata, s.wstrb);
          next_s.sec = wv[`RTCAI_SEC_LSB +: 6];
          next_s.min = wv[`RTCAI_MIN_LSB +: 6];
          next_s.hour = wv[`RTCAI_HOUR_LSB +: 5];
          next_s.day = wv[`RTCAI_DAY_LSB +: 3];
          next_s.div = 32'h0000_0000;
          next_s.tick = 1'b0;
        end
        `RTCAI_ALARM0_OFF: begin
          next_s.alm0 = merge(s.alm0, s.wdata, s.wstrb);
        end
        `RTCAI_ALARM1_OFF: begin
          next_s.alm1 = merge(s.alm1, s.wdata, s.wstrb);
        end
        default: begin
          next_s.bresp = `RTCAI_RESP_SLVERR;
        end
      endcase
    end
    // sticky flags: a match in the clearing cycle survives the clear
    next_s.status = (s.status & ~clr) | ev;
    // read channel: one read at a time, answered the cycle after the address
    if (s.rvalid && S_AXI_RREADY_IN) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && S_AXI_ARVALID_IN) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `RTCAI_RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        `RTCAI_CTRL_OFF: next_s.rdata = {29'h0, s.route, s.en1, s.en0};
        `RTCAI_STATUS_OFF: next_s.rdata = {30'h0, s.status};
        `RTCAI_MASK_OFF: next_s.rdata = {30'h0, s.mask};
        `RTCAI_TIME_OFF: next_s.rdata = time_word;
        `RTCAI_ALARM0_OFF: next_s.rdata = s.alm0;
        `RTCAI_ALARM1_OFF: next_s.rdata = s.alm1;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `RTCAI_RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    // pin drive from the flags and enables that will hold next cycle
    next_s.oe_a = (next_s.status[0] && next_s.en0) ||
                  (next_s.route && next_s.status[1] && next_s.en1);
    next_s.oe_b = next_s.status[1] && next_s.en1;
    next_s.irq = |(next_s.status & next_s.mask);
  end

  // state register; reset leaves every pin released and the bus idle
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s <= '0;
      s.day <= `RTCAI_DAY_RST;
    end else begin
      s <= next_s;
    end
  end

  assign S_AXI_AWREADY_OUT = s.awready;
  assign S_AXI_WREADY_OUT = s.wready;
  assign S_AXI_BVALID_OUT = s.bvalid;
  assign S_AXI_BRESP_OUT = s.bresp;
  assign S_AXI_ARREADY_OUT = s.arready;
  assign S_AXI_RVALID_OUT = s.rvalid;
  assign S_AXI_RRESP_OUT = s.rresp;
  assign S_AXI_RDATA_OUT = s.rdata;
  assign IRQ_OUT = s.irq;
  // open drain: the level is always low, only the enable switches
  assign ALARM_IRQ_OUT_A_OUT = 1'b0;
  assign ALARM_IRQ_OUT_B_OUT = 1'b0;
  assign ALARM_IRQ_OUT_A_OE_OUT = s.oe_a;
  assign ALARM_IRQ_OUT_B_OE_OUT = s.oe_b;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_match_tick(int k);
    s.tick && match[k];
  endsequence

  property p_pin_a_route;
    ALARM_IRQ_OUT_A_OE_OUT == ((s.status[0] && s.en0) || (s.route && s.status[1] && s.en1));
  endproperty
  a_pin_a_route: assert property (p_pin_a_route) else $error("pin a source wrong");

  property p_pin_b_alarm1;
    !(s.status[1] && s.en1) |-> !ALARM_IRQ_OUT_B_OE_OUT;
  endproperty
  a_pin_b_alarm1: assert property (p_pin_b_alarm1) else $error("pin b without alarm 1");

  property p_pin_b_hold;
    (s.status[1] && s.en1) |-> ALARM_IRQ_OUT_B_OE_OUT;
  endproperty
  a_pin_b_hold: assert property (p_pin_b_hold) else $error("pin b released early");

  property p_open_drain;
    (ALARM_IRQ_OUT_A_OE_OUT || ALARM_IRQ_OUT_B_OE_OUT) |->
      (!ALARM_IRQ_OUT_A_OUT && !ALARM_IRQ_OUT_B_OUT);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("alarm pin driven high");

  // a time write suppresses the tick, so every tick must have moved the time
  property p_time_runs;
    s.tick |-> !$stable(time_word);
  endproperty
  a_time_runs: assert property (p_time_runs) else $error("tick did not advance time");

  property p_alarm0_flag;
    s_match_tick(0) |=> s.status[0] ##1 s.status[0] || $past(s.aw_got);
  endproperty
  a_alarm0_flag: assert property (p_alarm0_flag) else $error("alarm 0 match lost");

  property p_alarm1_flag;
    s_match_tick(1) |=> s.status[1];
  endproperty
  a_alarm1_flag: assert property (p_alarm1_flag) else $error("alarm 1 match lost");

  property p_flag_no_spur;
    ($rose(s.status[0]) || $rose(s.status[1])) |-> $past(s.tick);
  endproperty
  a_flag_no_spur: assert property (p_flag_no_spur) else $error("spurious flag");

  property p_irq_level;
    IRQ_OUT == |(s.status & s.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq disagrees with flags");
endmodule
